/* File: bench/mas_link_chk.sv */
// Link protocol checker for the audio serial port pair
`timescale 1ns/1ps
`default_nettype none
module mas_link_chk (
  input wire logic core_clk, // Core clock
  input wire logic arst_n, // Reset, active low
  input wire logic bclk, // Resolved bit clock
  input wire logic lrclk, // Resolved frame clock
  input wire logic d2h, // Device data
  input wire logic h2d, // Host data
  input wire logic dev_bclk_oe, // Device drives bit clock
  input wire logic dev_lrclk_oe, // Device drives frame clock
  input wire logic host_bclk_oe, // Host drives bit clock
  input wire logic host_lrclk_oe // Host drives frame clock
);
  logic lr_q;
  logic armed;
  logic [8:0] fr_cnt;
  logic [7:0] hi_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Frame and pulse counters; reset restarts them so a new setup sees no stale frame
  always_ff @(posedge bclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lr_q <= 1'b0;
      armed <= 1'b0;
      fr_cnt <= 9'h000;
      hi_cnt <= 8'h00;
    end
    else
    begin
      lr_q <= lrclk;
      if (lrclk && !lr_q)
        armed <= 1'b1;
      if (lrclk && !lr_q)
        fr_cnt <= 9'h000;
      else if (fr_cnt != 9'h1ff)
        fr_cnt <= fr_cnt + 9'h001;
      if (!lrclk)
        hi_cnt <= 8'h00;
      else if (hi_cnt != 8'hff)
        hi_cnt <= hi_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Named steps of the clock shapes
  sequence bclk_shape;
    bclk ##1 !bclk [*2] ##1 bclk;
  endsequence
  sequence lr_fall;
    lr_q ##0 !lrclk;
  endsequence

  frame_len_a: assert property (@(posedge bclk) disable iff (!arst_n)
    (lrclk && !lr_q && armed) |-> fr_cnt == 9'h0ff) else $error("frame period is not 256 bit clocks");
  lr_width_a: assert property (@(posedge bclk) disable iff (!arst_n)
    lr_fall |-> (hi_cnt == 8'h01 || hi_cnt == 8'h80)) else $error("frame clock high time wrong");
  bclk_rate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(bclk) |=> bclk_shape) else $error("bit clock shape wrong");
  dev_own_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(dev_bclk_oe) |-> ##[0:40] dev_lrclk_oe) else $error("device drives only one clock");
  host_own_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(host_bclk_oe) |-> ##[0:40] host_lrclk_oe) else $error("host drives only one clock");
  dout_edge_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $changed(d2h) |-> $rose(bclk)) else $error("device data moved off the launch edge");
  hout_edge_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $changed(h2d) |-> $rose(bclk)) else $error("host data moved off the launch edge");
  lr_edge_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $changed(lrclk) |-> $rose(bclk)) else $error("frame clock moved off the launch edge");
endmodule
`default_nettype wire

/* File: bench/multiformat_audio_serial_port_tb.sv */
// Self-checking bench: device port against the partner end over one link
`timescale 1ns/1ps
`default_nettype none
module multiformat_audio_serial_port_tb
  import mas_pkg::*;
;
  localparam int LIMIT = 70000; // Eight setups of about six frames
  logic core_clk;
  logic arst_n;
  logic [MAS_AW-1:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic h_en;
  logic h_master;
  logic [1:0] h_fmt;
  logic [MAS_WORD-1:0] h_txl;
  logic [MAS_WORD-1:0] h_txr;
  logic [MAS_WORD-1:0] h_rxl;
  logic [MAS_WORD-1:0] h_rxr;
  logic h_rxv;
  logic [31:0] v;
  int n_mismatch;
  int n_tests;
  int cyc = 0;

  mas_link_if lnk();
  mas_port u_mas_port (.core_clk(core_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .lnk(lnk));
  mas_host u_mas_host (.core_clk(core_clk), .arst_n(arst_n), .enable(h_en), .master(h_master), .fmt(h_fmt),
    .tx_left(h_txl), .tx_right(h_txr), .rx_left(h_rxl), .rx_right(h_rxr), .rx_valid(h_rxv), .lnk(lnk));
  mas_link_chk u_mas_link_chk (.core_clk(core_clk), .arst_n(arst_n), .bclk(lnk.bclk), .lrclk(lnk.lrclk),
    .d2h(lnk.d2h), .h2d(lnk.h2d), .dev_bclk_oe(lnk.dev_bclk_oe), .dev_lrclk_oe(lnk.dev_lrclk_oe),
    .host_bclk_oe(lnk.host_bclk_oe), .host_lrclk_oe(lnk.host_lrclk_oe));

  ////////////////////////////////////////////////////////////////////////////
  // Core clock and hang guard
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_mismatch = n_mismatch + 1;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic test_done();
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [MAS_AW-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [MAS_AW-1:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic do_reset();
    arst_n <= 1'b0;
    h_en <= 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
  endtask
  // Shift one word off the device data line mid-bit, clear of the launch edge
  task automatic grab(input int lead, output logic [31:0] w);
    w = '0;
    @(posedge lnk.lrclk);
    repeat (lead - 1) @(posedge lnk.bclk);
    for (int i = 0; i < MAS_WORD; i++)
    begin
      @(negedge lnk.bclk);
      w = {w[30:0], lnk.d2h};
    end
  endtask
  // I2S frame clock rises at the second half, so slot one leads there
  function automatic logic [31:0] first_word(input logic [1:0] f, input logic [23:0] s0, input logic [23:0] s1);
    return {8'h00, (f == MAS_FMT_I2S) ? s1 : s0};
  endfunction
  // Channel k at slot k, channels zero and one swapped on request
  function automatic logic [31:0] slots(input logic sw);
    return sw ? 32'h00fa_c681 : 32'h00fa_c688;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // One setup: device master or slave, both directions, wire and register checks
  task automatic run(input logic dm, input logic [1:0] df, input logic [1:0] hf, input logic sw,
    input logic [23:0] a, input logic [23:0] b);
    logic [23:0] s0;
    logic [23:0] s1;
    int n;
    s0 = sw ? b : a;
    s1 = sw ? a : b;
    do_reset();
    h_master <= !dm;
    h_fmt <= hf;
    h_txl <= MAS_WORD'($urandom());
    h_txr <= MAS_WORD'($urandom());
    wr_reg(MAS_REG_CHEN, 32'h0000_0303);
    wr_reg(MAS_REG_TXSLOT, slots(sw));
    wr_reg(MAS_REG_RXSLOT, slots(1'b0));
    wr_reg(5'h08, {8'h00, a});
    wr_reg(5'h09, {8'h00, b});
    wr_reg(MAS_REG_CTRL, {28'h000_0000, df, dm, 1'b1});
    h_en <= 1'b1;
    // A transmit word reaches the wire in the frame after next; count received pairs meanwhile
    n = 0;
    repeat (5 * 1024)
    begin
      @(posedge core_clk);
      n = n + int'(h_rxv);
    end
    check("rx pulses", {31'h0000_0000, n >= 4 && n <= 6}, 32'h0000_0001);
    check("host left", {8'h00, h_rxl}, {8'h00, s0});
    check("host right", {8'h00, h_rxr}, {8'h00, s1});
    grab(hf[0] ? 1 : 2, v);
    check("wire word", v, first_word(hf, s0, s1));
    rd_reg(5'h10, v);
    check("dev rx left", v, {8'h00, h_txl});
    rd_reg(5'h11, v);
    check("dev rx right", v, {8'h00, h_txr});
    rd_reg(MAS_REG_STAT, v);
    check("frames", {31'h0000_0000, v >= 32'd3 && v <= 32'd7}, 32'h0000_0001);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    arst_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    h_en = 1'b0;
    h_master = 1'b0;
    h_fmt = 2'h0;
    h_txl = '0;
    h_txr = '0;
    n_mismatch = 0;
    n_tests = 0;
    v = 32'($urandom(32'h0000_a8d4));
    do_reset();
    rd_reg(MAS_REG_STAT, v);
    check("stat reset", v, 32'h0000_0000);
    wr_reg(MAS_REG_CHEN, 32'h0000_0303);
    rd_reg(MAS_REG_CHEN, v);
    check("chen", v, 32'h0000_0303);
    @(posedge core_clk);
    #1;
    check("rdata idle", rdata, 32'h0000_0000);
    wr_reg(5'h10, 32'h0000_5a5a);
    rd_reg(5'h10, v);
    check("rx word ro", v, 32'h0000_0000);
    rd_reg(5'h1f, v);
    check("unmapped", v, 32'h0000_0000);
    // Inversion bits while disabled and slave, so no pin moves
    wr_reg(MAS_REG_CTRL, 32'h0000_0030);
    rd_reg(MAS_REG_CTRL, v);
    check("ctrl", v, 32'h0000_0030);
    run(1'b1, MAS_FMT_DSP_A, MAS_FMT_DSP_A, 1'b0, 24'h80_0000, 24'h7f_ffff);
    run(1'b1, MAS_FMT_DSP_B, MAS_FMT_DSP_B, 1'b1, MAS_WORD'($urandom()), MAS_WORD'($urandom()));
    run(1'b1, MAS_FMT_I2S, MAS_FMT_I2S, 1'b0, MAS_WORD'($urandom()), MAS_WORD'($urandom()));
    run(1'b1, MAS_FMT_LJ, MAS_FMT_LJ, 1'b0, 24'hff_ffff, 24'h00_0001);
    run(1'b0, MAS_FMT_DSP_A, MAS_FMT_DSP_A, 1'b0, MAS_WORD'($urandom()), MAS_WORD'($urandom()));
    run(1'b0, MAS_FMT_I2S, MAS_FMT_I2S, 1'b1, MAS_WORD'($urandom()), MAS_WORD'($urandom()));
    // Slave refuses the master-only formats and falls back
    run(1'b0, MAS_FMT_DSP_B, MAS_FMT_DSP_A, 1'b0, MAS_WORD'($urandom()), MAS_WORD'($urandom()));
    run(1'b0, MAS_FMT_LJ, MAS_FMT_I2S, 1'b0, MAS_WORD'($urandom()), MAS_WORD'($urandom()));
    test_done();
  end
endmodule
`default_nettype wire

/* File: core/mas_host.sv */
// Partner end of the link: stereo processor side, master or slave
`timescale 1ns/1ps
`default_nettype none
module mas_host
  import mas_pkg::*;
(
  input wire logic core_clk, // Core clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic enable, // Link running
  input wire logic master, // Host makes both clocks
  input wire logic [1:0] fmt, // Data format
  input wire logic [MAS_WORD-1:0] tx_left, // Left word to send
  input wire logic [MAS_WORD-1:0] tx_right, // Right word to send
  output logic [MAS_WORD-1:0] rx_left, // Left word received
  output logic [MAS_WORD-1:0] rx_right, // Right word received
  output logic rx_valid, // Pulse: new received pair
  mas_link_if.host lnk // Link pins
);

  typedef struct packed {
    logic [2:0] tgl_s;
    logic [1:0][MAS_WORD-1:0] shadow;
    logic [1:0][MAS_WORD-1:0] rx;
    logic rx_valid;
    logic [MAS_DIV_W-1:0] div;
    logic bclk_o;
    logic drive_clk;
  } mas_hcore_t;

  typedef struct packed {
    logic [1:0][3:0] cfg_s;
    logic [MAS_CNT_W-1:0] cnt;
    logic lr_q;
    logic [1:0][MAS_WORD-1:0] tx_buf;
    logic [1:0][MAS_WORD-1:0] rx_acc;
    logic [1:0][MAS_WORD-1:0] rx_buf;
    logic tgl;
    logic sdo;
    logic lro;
  } mas_hlink_t;

  mas_hcore_t c;
  mas_hcore_t next_c;
  mas_hlink_t l;
  mas_hlink_t next_l;

  ////////////////////////////////////////////////////////////////////////////
  // Core side: clock divider and frame handshake
  always_comb
  begin
    next_c = c;
    next_c.rx_valid = 1'b0;
    next_c.tgl_s = {c.tgl_s[1:0], l.tgl};
    next_c.drive_clk = master;
    // R04: clocks made here only as master
    if (enable && master)
    begin
      next_c.div = (c.div == MAS_DIV_TOP) ? '0 : c.div + 1'b1;
      if (c.div == MAS_DIV_TOP)
        next_c.bclk_o = ~c.bclk_o;
    end
    else
    begin
      next_c.div = '0;
      next_c.bclk_o = 1'b0;
    end
    // Frame toggle: buffers are stable for a whole frame after it
    if (c.tgl_s[2] ^ c.tgl_s[1])
    begin
      next_c.shadow = {tx_right, tx_left};
      next_c.rx = l.rx_buf;
      next_c.rx_valid = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      c <= '0;
    else
      c <= next_c;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side, on the shared bit clock
  always_comb
  begin
    logic h_en;
    logic h_mst;
    logic [1:0] h_fmt;
    logic [MAS_CNT_W-1:0] nc;
    mas_place_t rp;
    mas_place_t tp;
    next_l = l;
    h_en = l.cfg_s[1][0];
    h_mst = l.cfg_s[1][1];
    h_fmt = l.cfg_s[1][3:2];
    next_l.cfg_s = {l.cfg_s[0], fmt, master, enable};
    next_l.lr_q = lnk.lrclk;
    // R12: slave locks on the rising pulse edge in DSP formats, on both frame edges in I2S and left-justified, any pulse width
    nc = h_en ? mas_next_cnt(l.cnt, lnk.lrclk, l.lr_q, h_mst, h_fmt) : '0;
    // R10: DSP B slave wraps freely, its MSB leaves with the pulse
    if (h_en && !h_mst && h_fmt == MAS_FMT_DSP_B && l.cnt == MAS_LAST)
      nc = '0;
    // R17: one counter serves both directions
    next_l.cnt = nc;
    // R19: sample on the rising edge
    rp = mas_place(l.cnt - MAS_FIRST, h_fmt);
    if (h_en && rp.valid && rp.slot < 2)
      next_l.rx_acc[rp.slot[0]][MAS_WORD_MSB - rp.bitn] = lnk.d2h;
    if (h_en && nc == MAS_FIRST)
    begin
      next_l.rx_buf = l.rx_acc;
      next_l.tx_buf = c.shadow;
      next_l.tgl = ~l.tgl;
    end
    // R07 R11: MSB first, right word in next slot
    // R13: a mono sample travels as the left word in slot 0
    tp = mas_place(nc - MAS_FIRST, h_fmt);
    next_l.sdo = h_en & tp.valid & (tp.slot < 2) & next_l.tx_buf[tp.slot[0]][MAS_WORD_MSB - tp.bitn];
    // R14 R15: frame clock lead per format
    next_l.lro = h_en & mas_lr_level(nc - MAS_CNT_W'(h_fmt[0]), h_fmt);
  end

  always_ff @(posedge lnk.bclk or negedge arst_n)
  begin
    if (!arst_n)
      l <= '0;
    else
      l <= next_l;
  end

  // Outputs straight from flip-flops
  assign rx_left = c.rx[0];
  assign rx_right = c.rx[1];
  assign rx_valid = c.rx_valid;
  assign lnk.host_bclk_o = c.bclk_o;
  assign lnk.host_bclk_oe = c.drive_clk;
  assign lnk.host_lrclk_o = l.lro;
  assign lnk.host_lrclk_oe = c.drive_clk;
  assign lnk.h2d = l.sdo;

endmodule
`default_nettype wire

/* File: core/mas_link_if.sv */
// Serial audio link between the port and its partner, with pin resolution
`timescale 1ns/1ps
`default_nettype none
interface mas_link_if;
  logic dev_bclk_o;
  logic dev_bclk_oe;
  logic dev_lrclk_o;
  logic dev_lrclk_oe;
  logic host_bclk_o;
  logic host_bclk_oe;
  logic host_lrclk_o;
  logic host_lrclk_oe;
  logic bclk;
  logic lrclk;
  logic d2h;
  logic h2d;

  // Shared clock wires; an undriven wire reads low as if pulled down
  assign bclk = dev_bclk_oe ? dev_bclk_o : (host_bclk_oe ? host_bclk_o : 1'b0);
  assign lrclk = dev_lrclk_oe ? dev_lrclk_o : (host_lrclk_oe ? host_lrclk_o : 1'b0);

  modport dev (input bclk, input lrclk, input h2d, output dev_bclk_o, output dev_bclk_oe,
    output dev_lrclk_o, output dev_lrclk_oe, output d2h);
  modport host (input bclk, input lrclk, input d2h, output host_bclk_o, output host_bclk_oe,
    output host_lrclk_o, output host_lrclk_oe, output h2d);
endinterface
`default_nettype wire

/* File: core/mas_pkg.sv */
// Shared constants, types and slot placement helpers for the audio serial port
package mas_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Port and frame geometry
  localparam int MAS_CH_WIDE = 8; // Channels each way, ports one and two
  localparam int MAS_CH_NARROW = 2; // Channels each way, ports three and four
  localparam int MAS_SLOTS = 8; // Slots per frame
  localparam int MAS_CNT_W = 8; // Bit position in frame, 8 slots x 32 bclk
  localparam int MAS_SLOT_W = 5; // 32 bclk cycles per slot
  localparam int MAS_WORD = 24; // Valid bits per slot
  localparam int MAS_WORD_MSB = MAS_WORD - 1;
  localparam logic [MAS_CNT_W-1:0] MAS_HALF = 8'h80; // Start of second half-frame
  localparam logic [MAS_CNT_W-1:0] MAS_LAST = 8'hff; // Last position of a frame
  localparam logic [MAS_CNT_W-1:0] MAS_FIRST = 8'h01; // Position of the first data bit

  ////////////////////////////////////////////////////////////////////////////
  // Data formats; bit 1 marks half-frame formats, bit 0 marks no delay bit
  localparam logic [1:0] MAS_FMT_DSP_A = 2'h0;
  localparam logic [1:0] MAS_FMT_DSP_B = 2'h1;
  localparam logic [1:0] MAS_FMT_I2S = 2'h2;
  localparam logic [1:0] MAS_FMT_LJ = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices and fields
  localparam int MAS_AW = 5;
  localparam logic [MAS_AW-1:0] MAS_REG_CTRL = 5'h00;
  localparam logic [MAS_AW-1:0] MAS_REG_CHEN = 5'h01;
  localparam logic [MAS_AW-1:0] MAS_REG_TXSLOT = 5'h02;
  localparam logic [MAS_AW-1:0] MAS_REG_RXSLOT = 5'h03;
  localparam logic [MAS_AW-1:0] MAS_REG_STAT = 5'h04;
  localparam logic [1:0] MAS_BANK_TXD = 2'h1; // Indices 0x08..0x0F
  localparam logic [1:0] MAS_BANK_RXD = 2'h2; // Indices 0x10..0x17
  localparam int MAS_CTL_EN = 0;
  localparam int MAS_CTL_MASTER = 1;
  localparam int MAS_CTL_FMT = 2;
  localparam int MAS_CTL_BINV = 4;
  localparam int MAS_CTL_LINV = 5;
  localparam int MAS_CTL_W = 6;
  localparam int MAS_RXEN_LSB = 8;
  localparam int MAS_SLOTF_W = 3;
  localparam int MAS_STAT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Master bit clock generation
  localparam int MAS_CORE_NS = 50; // Core clock period
  localparam int MAS_BCLK_HALF_NS = 100; // Master bit clock half period
  localparam int MAS_BCLK_HALF_CYC = MAS_BCLK_HALF_NS / MAS_CORE_NS;
  localparam int MAS_DIV_W = 2;
  localparam logic [MAS_DIV_W-1:0] MAS_DIV_TOP = MAS_DIV_W'(MAS_BCLK_HALF_CYC - 1);

  typedef struct packed {
    logic valid;
    logic [MAS_CNT_W-MAS_SLOT_W-1:0] slot;
    logic [MAS_SLOT_W-1:0] bitn;
  } mas_place_t;

  // Slot and bit carried at data offset d of the frame
  function automatic mas_place_t mas_place(input logic [MAS_CNT_W-1:0] d, input logic [1:0] fmt);
    mas_place_t r;
    r.bitn = d[MAS_SLOT_W-1:0];
    r.valid = (r.bitn < MAS_SLOT_W'(MAS_WORD));
    if (fmt[1])
      r.slot = {d[MAS_CNT_W-2:MAS_SLOT_W], d[MAS_CNT_W-1]};
    else
      r.slot = d[MAS_CNT_W-1:MAS_SLOT_W];
    return r;
  endfunction

  // Frame clock level at frame position p, non-inverted
  function automatic logic mas_lr_level(input logic [MAS_CNT_W-1:0] p, input logic [1:0] fmt);
    if (fmt[1])
      return p[MAS_CNT_W-1] ^ fmt[0];
    return (p == '0);
  endfunction

  // Next frame position; a slave locks to frame clock edges
  function automatic logic [MAS_CNT_W-1:0] mas_next_cnt(input logic [MAS_CNT_W-1:0] cnt, input logic lr,
    input logic lr_q, input logic master, input logic [1:0] fmt);
    logic seen;
    logic [MAS_CNT_W-1:0] base;
    seen = fmt[1] ? (lr ^ lr_q) : (lr & ~lr_q);
    base = (fmt[1] && lr == mas_lr_level(MAS_HALF, fmt)) ? MAS_HALF : '0;
    if (!master && seen)
      return base + MAS_CNT_W'(fmt[0]) + MAS_FIRST;
    if (!master && !fmt[1] && cnt == MAS_LAST)
      return cnt;
    return cnt + MAS_FIRST;
  endfunction

endpackage

/* File: core/mas_port.sv */
// Device end: one audio serial port with registers and slot mapping
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R01: four ports, 8 or 2 channels each way
// R02: transmit and receive configured independently
// R03: data out, data in, bit and frame clock
// R04: master drives clocks, slave takes them in
// R05: formats DSP A, DSP B, I2S, left-justified
// R06: left-justified and DSP B master only
// R07: words two's complement, MSB first
// R08: single stereo pair uses slot zero
// R09: bit and frame clock polarity invertible
// R10: DSP MSB one or two edges after pulse
// R11: DSP right word follows left, no gap
// R12: slave frame pulse any width below frame
// R13: mono PCM carried as left channel
// R14: I2S MSB on second edge after transition
// R15: left-justified MSB on first edge after transition
// R16: per-channel slot position, any order
// R17: one sample rate per port
// R18: DSP slots consecutive; I2S even first half
// R19: data changes after the sampling edge
module mas_port
  import mas_pkg::*;
#(
  parameter int CH = MAS_CH_WIDE // Channels each way
)(
  input wire logic core_clk, // Core clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic [MAS_AW-1:0] addr, // Register index
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after rd
  mas_link_if.dev lnk // Link pins
);

  typedef struct packed {
    logic [MAS_CTL_W-1:0] ctrl;
    logic [CH-1:0] tx_en;
    logic [CH-1:0] rx_en;
    logic [CH-1:0][MAS_SLOTF_W-1:0] tx_slot;
    logic [CH-1:0][MAS_SLOTF_W-1:0] rx_slot;
    logic [CH-1:0][MAS_WORD-1:0] tx_word;
    logic [CH-1:0][MAS_WORD-1:0] rx_word;
    logic [MAS_SLOTS-1:0][MAS_WORD-1:0] shadow;
    logic [2:0] tgl_s;
    logic [MAS_STAT_W-1:0] frames;
    logic [31:0] rdata;
    logic [MAS_DIV_W-1:0] div;
    logic bclk_raw;
    logic bclk_o;
    logic drive_clk;
  } mas_core_t;

  typedef struct packed {
    logic [1:0][MAS_CTL_W-1:0] cfg_s;
    logic [MAS_CNT_W-1:0] cnt;
    logic lr_q;
    logic [MAS_SLOTS-1:0][MAS_WORD-1:0] tx_buf;
    logic [MAS_SLOTS-1:0][MAS_WORD-1:0] rx_acc;
    logic [MAS_SLOTS-1:0][MAS_WORD-1:0] rx_buf;
    logic tgl;
    logic sdo;
    logic lro;
  } mas_link_t;

  mas_core_t c;
  mas_core_t next_c;
  mas_link_t l;
  mas_link_t next_l;
  logic link_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Core side: registers, clock divider, frame handshake
  always_comb
  begin
    next_c = c;
    next_c.rdata = '0;
    next_c.tgl_s = {c.tgl_s[1:0], l.tgl};
    // R02: separate enables and slot maps for each direction
    if (wr)
    begin
      case (addr)
        MAS_REG_CTRL: next_c.ctrl = wdata[MAS_CTL_W-1:0];
        MAS_REG_CHEN:
        begin
          next_c.tx_en = wdata[CH-1:0];
          next_c.rx_en = wdata[MAS_RXEN_LSB +: CH];
        end
        MAS_REG_TXSLOT: next_c.tx_slot = wdata[CH*MAS_SLOTF_W-1:0];
        MAS_REG_RXSLOT: next_c.rx_slot = wdata[CH*MAS_SLOTF_W-1:0];
        default:
        begin
          // R01: channel count set by CH
          if (addr[4:3] == MAS_BANK_TXD && int'(addr[2:0]) < CH)
            next_c.tx_word[addr[2:0]] = wdata[MAS_WORD-1:0];
        end
      endcase
    end
    // Reads answer one cycle later; unmapped reads give zero
    if (rd)
    begin
      case (addr)
        MAS_REG_CTRL: next_c.rdata = 32'(c.ctrl);
        MAS_REG_CHEN: next_c.rdata = 32'(c.tx_en) | (32'(c.rx_en) << MAS_RXEN_LSB);
        MAS_REG_TXSLOT: next_c.rdata = 32'(c.tx_slot);
        MAS_REG_RXSLOT: next_c.rdata = 32'(c.rx_slot);
        MAS_REG_STAT: next_c.rdata = 32'(c.frames);
        default:
        begin
          if (addr[4:3] == MAS_BANK_TXD && int'(addr[2:0]) < CH)
            next_c.rdata = 32'(c.tx_word[addr[2:0]]);
          else if (addr[4:3] == MAS_BANK_RXD && int'(addr[2:0]) < CH)
            next_c.rdata = 32'(c.rx_word[addr[2:0]]);
        end
      endcase
    end
    // R04: bit clock derived here only while master and enabled
    next_c.drive_clk = c.ctrl[MAS_CTL_MASTER];
    if (c.ctrl[MAS_CTL_EN] && c.ctrl[MAS_CTL_MASTER])
    begin
      next_c.div = (c.div == MAS_DIV_TOP) ? '0 : c.div + 1'b1;
      if (c.div == MAS_DIV_TOP)
        next_c.bclk_raw = ~c.bclk_raw;
    end
    else
    begin
      next_c.div = '0;
      next_c.bclk_raw = 1'b0;
    end
    // R09: inverted bit clock
    next_c.bclk_o = next_c.bclk_raw ^ c.ctrl[MAS_CTL_BINV];
    // Frame toggle: link buffers stay put for a frame, so words cross safely
    if (c.tgl_s[2] ^ c.tgl_s[1])
    begin
      next_c.frames = c.frames + 1'b1;
      // R16: each enabled channel lands in its own slot
      next_c.shadow = '0;
      for (int k = 0; k < CH; k++)
      begin
        if (c.tx_en[k])
          next_c.shadow[c.tx_slot[k]] = c.tx_word[k];
        if (c.rx_en[k])
          next_c.rx_word[k] = l.rx_buf[c.rx_slot[k]];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      c <= '0;
    else
      c <= next_c;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side, on the pin bit clock; polarity is quasi-static, change it idle
  // R09: undo inversion so data rules see the rising edge
  assign link_clk = lnk.bclk ^ c.ctrl[MAS_CTL_BINV];

  always_comb
  begin
    logic en;
    logic mst;
    logic lr_in;
    logic [1:0] fmt;
    logic [MAS_CNT_W-1:0] nc;
    mas_place_t rp;
    mas_place_t tp;
    next_l = l;
    en = l.cfg_s[1][MAS_CTL_EN];
    mst = l.cfg_s[1][MAS_CTL_MASTER];
    // R05: format field picks one of four
    // R06: as slave, DSP B falls back to DSP A, left-justified to I2S
    fmt = mst ? l.cfg_s[1][MAS_CTL_FMT +: 2] : {l.cfg_s[1][MAS_CTL_FMT + 1], 1'b0};
    // R09: inverted frame clock
    lr_in = lnk.lrclk ^ l.cfg_s[1][MAS_CTL_LINV];
    next_l.cfg_s = {l.cfg_s[0], c.ctrl};
    next_l.lr_q = lr_in;
    // R12: slave locks to the rising pulse edge in DSP A, to both frame clock edges in I2S; width not checked
    // R17: one frame counter serves both directions
    nc = en ? mas_next_cnt(l.cnt, lr_in, l.lr_q, mst, fmt) : '0;
    next_l.cnt = nc;
    // R13: mono input lands in slot 0, left
    // R19: capture on the rising edge the bit driven after the previous one
    // R18: slot order from placement per format
    rp = mas_place(l.cnt - MAS_FIRST, fmt);
    if (en && rp.valid)
      next_l.rx_acc[rp.slot][MAS_WORD_MSB - rp.bitn] = lnk.h2d;
    // Frame start: hand received words over, take new ones in
    if (en && nc == MAS_FIRST)
    begin
      next_l.rx_buf = l.rx_acc;
      next_l.tx_buf = c.shadow;
      next_l.tgl = ~l.tgl;
    end
    // R07: MSB first, word sent as stored
    // R08: slot 0 is the first word after the frame start
    // R11: slots back to back; bits past the word drive low
    tp = mas_place(nc - MAS_FIRST, fmt);
    next_l.sdo = en & tp.valid & next_l.tx_buf[tp.slot][MAS_WORD_MSB - tp.bitn];
    // R10: DSP A pulse one bit ahead of the MSB, DSP B with it
    // R14: I2S edge one bit ahead of the MSB
    // R15: left-justified edge together with the MSB
    next_l.lro = (en & mas_lr_level(nc - MAS_CNT_W'(fmt[0]), fmt)) ^ l.cfg_s[1][MAS_CTL_LINV];
  end

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
      l <= '0;
    else
      l <= next_l;
  end

  ////////////////////////////////////////////////////////////////////////////
  // R03: bit clock, frame clock and data out all from flip-flops; data in is an input
  assign rdata = c.rdata;
  assign lnk.dev_bclk_o = c.bclk_o;
  assign lnk.dev_bclk_oe = c.drive_clk;
  assign lnk.dev_lrclk_o = l.lro;
  assign lnk.dev_lrclk_oe = c.drive_clk;
  assign lnk.d2h = l.sdo;

endmodule
`default_nettype wire
